/* hw/tiw_top.sv */
`timescale 1ns/10ps

// Functional notes
// - Twelve-bit timebase counts every clock, reset clears.
// - Timebase count is never software visible.
// - Wrap from all ones sets overflow flag.
// - Flag and enable hold timebase interrupt high.
// - Writing one keeps flag; zero clears it.
// - Control: wake enable 7, flag 1, enable 0.
// - Idle bit toggles per wrap; wakes idle.
// - Idle overflow indication is never software visible.
// - Four-bit watchdog; fifteenth count forces reset.
// - After reset delay, fetch restarts at 0xC00.
// - Watchdog always counts; fuse gates the reset.
// - Fuse changes only in programming mode, protected.
// - Service key allowed between 4096 and 61440.
// - Accepted service clears watchdog count to zero.
// - Watchdog keeps counting during idle mode.
// - Wake enable passes shared wake pending interrupt.
module tiw_top
   import tiw_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Core and wake-up side
   input wire logic idle_req_i,
   input wire logic wake_pend_i,
   input wire logic prog_mode_i,
   input wire logic write_protect_i,
   input wire logic fuse_init_i,
   output logic idle_o,
   output logic timebase_interrupt_o,
   output logic wake_irq_o,
   output logic irq_o,
   output logic wdt_reset_o,
   output logic watchdog_enable_fuse_o,
   output logic fetch_start_o,
   output logic [11:0] fetch_pc_o
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [9:0] idx, input logic [9:0] want);
      hit = (idx == want);
   endfunction

   // Set wins over clear, so an event in the clearing cycle survives.
   function automatic logic [3:0] sticky(input logic [3:0] old, input logic [3:0] set,
                                         input logic [3:0] clr);
      sticky = set | (old & ~clr);
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   tiw_regs_t s;
   tiw_regs_t n;
   logic ovf;
   logic wr;
   logic [7:0] wb;
   logic [3:0] ev;
   logic [3:0] clr;
   logic trip;
   logic addr_ph;

   always_comb begin
      n = s;
      ev = 4'h0;
      clr = 4'h0;
      trip = 1'b0;
      wb = hwdata_i[7:0];
      wr = s.a_we;
      addr_ph = hsel_i & htrans_i[1] & hready_i;
      n.fetch_go = 1'b0;
      n.hready = 1'b1;
      ovf = (s.cnt == TB_MAX);

      // -------------------------------------------------------------
      // Timebase, idle timer and watchdog
      // -------------------------------------------------------------
      n.cnt = s.cnt + 12'h001;
      if (ovf) begin
         ev[EV_OVF] = 1'b1;
         n.idle_ext = ~s.idle_ext;
         // Counting does not look at idle, so a lapse resets in idle too.
         if (s.wd_cnt == WD_LAST) begin
            ev[EV_LATE] = 1'b1;
            n.wd_cnt = 4'h0;
         end else begin
            n.wd_cnt = s.wd_cnt + 4'h1;
         end
      end
      if (wr && hit(s.a_idx, IDX_SERVICE) && wb == SERVICE_KEY) begin
         if (s.wd_cnt == 4'h0) begin
            ev[EV_EARLY] = 1'b1;
         end else begin
            n.wd_cnt = 4'h0;
         end
      end
      // Any other value written to the service register falls through.
      trip = s.fuse & (ev[EV_LATE] | ev[EV_EARLY]);

      // -------------------------------------------------------------
      // Idle mode
      // -------------------------------------------------------------
      if (s.idle) begin
         if ((ovf && s.idle_ext) || wake_pend_i) begin
            n.idle = 1'b0;
            ev[EV_WAKE] = 1'b1;
         end
      end else if (idle_req_i) begin
         n.idle = 1'b1;
      end

      // -------------------------------------------------------------
      // Register writes
      // -------------------------------------------------------------
      if (wr && hit(s.a_idx, IDX_CONTROL)) begin
         n.wk_ie = wb[CTL_WAKE_IE];
         n.tb_ie = wb[CTL_TB_IE];
      end
      if (ev[EV_OVF]) begin
         n.tb_flag = 1'b1;
      end else if (wr && hit(s.a_idx, IDX_CONTROL) && !wb[CTL_TB_FLAG]) begin
         n.tb_flag = 1'b0;
      end
      if (wr && hit(s.a_idx, IDX_STATUS)) begin
         clr = hwdata_i[3:0];
      end
      n.sts = sticky(s.sts, ev, clr);
      if (wr && hit(s.a_idx, IDX_MASK)) begin
         n.msk = hwdata_i[3:0];
      end
      if (s.fuse_load) begin
         n.fuse = fuse_init_i;
         n.fuse_load = 1'b0;
      end else if (wr && hit(s.a_idx, IDX_FUSE) && prog_mode_i) begin
         // Protection only blocks clearing; setting is always allowed.
         if (wb[FUSE_WATCHDOG_ENABLE_FUSE] || !write_protect_i) begin
            n.fuse = wb[FUSE_WATCHDOG_ENABLE_FUSE];
         end
      end

      // -------------------------------------------------------------
      // Watchdog reset sequence
      // -------------------------------------------------------------
      case (s.st)
         TIW_RUN: begin
            if (trip) begin
               n.st = TIW_HOLD;
               n.hold = RST_HOLD_CYC;
            end
         end
         TIW_HOLD: begin
            n.hold = s.hold - 5'h01;
            if (s.hold == 5'h01) begin
               n.st = TIW_FETCH;
            end
         end
         TIW_FETCH: begin
            n.st = TIW_RUN;
            n.fetch_go = 1'b1;
         end
         default: begin
            n.st = TIW_RUN;
         end
      endcase
      if (n.st != TIW_RUN) begin
         // Timebase, watchdog, idle and interrupt state is reinitialised while the reset is held; the fuse keeps its value.
         n.cnt = 12'h000;
         n.idle_ext = 1'b0;
         n.wd_cnt = 4'h0;
         n.tb_flag = 1'b0;
         n.tb_ie = CONTROL_RST[CTL_TB_IE];
         n.wk_ie = CONTROL_RST[CTL_WAKE_IE];
         n.sts = EV_RST;
         n.msk = EV_RST;
         n.idle = 1'b0;
      end
      n.wd_rst = (n.st == TIW_HOLD);
      n.pc = RESTART_PC;

      // -------------------------------------------------------------
      // Outputs
      // -------------------------------------------------------------
      if (n.tb_flag && n.tb_ie) begin
         n.tb_irq = 1'b1;
      end else begin
         n.tb_irq = 1'b0;
      end

      if (wake_pend_i && n.wk_ie) begin
         n.wk_irq = 1'b1;
      end else begin
         n.wk_irq = 1'b0;
      end

      n.irq = |(n.sts & n.msk);

      // -------------------------------------------------------------
      // Bus address phase
      // -------------------------------------------------------------
      // Read data is taken from the next state so a write just before
      // a read is seen at once, at no wait state.
      n.a_we = addr_ph & hwrite_i;
      n.a_idx = haddr_i[11:2];
      n.hrdata = 32'h0000_0000;
      if (addr_ph && !hwrite_i && haddr_i[31:12] == 20'h00000) begin
         case (haddr_i[11:2])
            IDX_CONTROL: begin
               n.hrdata[CTL_WAKE_IE] = n.wk_ie;
               n.hrdata[CTL_TB_FLAG] = n.tb_flag;
               n.hrdata[CTL_TB_IE] = n.tb_ie;
            end
            IDX_STATUS: begin
               n.hrdata[3:0] = n.sts;
            end
            IDX_MASK: begin
               n.hrdata[3:0] = n.msk;
            end
            IDX_FUSE: begin
               n.hrdata[FUSE_WATCHDOG_ENABLE_FUSE] = n.fuse;
               n.hrdata[FUSE_PROT] = write_protect_i;
               n.hrdata[FUSE_PROG] = prog_mode_i;
            end
            default: begin
               // The counters and the service register have no read path.
               n.hrdata = 32'h0000_0000;
            end
         endcase
      end

      if (!addr_ph || haddr_i[31:12] != 20'h00000) begin
         n.a_we = 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         s.st <= TIW_RUN;
         s.cnt <= 12'h000;
         s.idle_ext <= 1'b0;
         s.wd_cnt <= 4'h0;
         s.tb_flag <= CONTROL_RST[CTL_TB_FLAG];
         s.tb_ie <= CONTROL_RST[CTL_TB_IE];
         s.wk_ie <= CONTROL_RST[CTL_WAKE_IE];
         s.sts <= EV_RST;
         s.msk <= EV_RST;
         s.fuse <= 1'b0;
         // The stored enable is fetched on the first edge after release.
         s.fuse_load <= 1'b1;
         s.idle <= 1'b0;
         s.hold <= 5'h00;
         s.a_idx <= 10'h000;
         s.a_we <= 1'b0;
         s.irq <= 1'b0;
         s.tb_irq <= 1'b0;
         s.wk_irq <= 1'b0;
         s.wd_rst <= 1'b0;
         s.fetch_go <= 1'b0;
         s.pc <= RESTART_PC;
         s.hrdata <= 32'h0000_0000;
         s.hready <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // ---------------------------------------------------------------
   // Bus outputs
   // ---------------------------------------------------------------
   // The slave never stalls, so the bus always sees OKAY and ready.
   assign hrdata_o = s.hrdata;
   assign hreadyout_o = s.hready;
   assign hresp_o = s.a_we & 1'b0;

   // ---------------------------------------------------------------
   // Interrupt and idle outputs
   // ---------------------------------------------------------------
   assign idle_o = s.idle;
   assign timebase_interrupt_o = s.tb_irq;
   assign wake_irq_o = s.wk_irq;
   assign irq_o = s.irq;

   // ---------------------------------------------------------------
   // Reset and fetch outputs
   // ---------------------------------------------------------------
   assign wdt_reset_o = s.wd_rst;
   assign watchdog_enable_fuse_o = s.fuse;
   assign fetch_start_o = s.fetch_go;
   assign fetch_pc_o = s.pc;

endmodule // tiw_top

/* inc/tiw_pkg.sv */
package tiw_pkg;

   // ---------------------------------------------------------------
   // Register indices
   // ---------------------------------------------------------------
   localparam logic [9:0] IDX_SERVICE = 10'h0B5;
   localparam logic [9:0] IDX_CONTROL = 10'h0B6;
   localparam logic [9:0] IDX_STATUS = 10'h0B7;
   localparam logic [9:0] IDX_MASK = 10'h0B8;
   localparam logic [9:0] IDX_FUSE = 10'h0B9;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTL_WAKE_IE = 7;
   localparam int CTL_TB_FLAG = 1;
   localparam int CTL_TB_IE = 0;
   localparam int EV_OVF = 0;
   localparam int EV_WAKE = 1;
   localparam int EV_EARLY = 2;
   localparam int EV_LATE = 3;
   localparam int FUSE_WATCHDOG_ENABLE_FUSE = 0;
   localparam int FUSE_PROT = 1;
   localparam int FUSE_PROG = 2;

   // ---------------------------------------------------------------
   // Reset values, patterns and counts
   // ---------------------------------------------------------------
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [3:0] EV_RST = 4'h0;
   localparam logic [7:0] SERVICE_KEY = 8'h1B;
   localparam logic [11:0] TB_MAX = 12'hFFF;
   localparam logic [3:0] WD_LAST = 4'hE;
   localparam logic [11:0] RESTART_PC = 12'hC00;
   localparam logic [4:0] RST_HOLD_CYC = 5'h10;

   typedef enum logic [1:0] {
      TIW_RUN = 2'b00,
      TIW_HOLD = 2'b01,
      TIW_FETCH = 2'b11
   } tiw_state_t;

   typedef struct packed {
      tiw_state_t st;
      logic [11:0] cnt;
      logic idle_ext;
      logic [3:0] wd_cnt;
      logic tb_flag;
      logic tb_ie;
      logic wk_ie;
      logic [3:0] sts;
      logic [3:0] msk;
      logic fuse;
      logic fuse_load;
      logic idle;
      logic [4:0] hold;
      logic [9:0] a_idx;
      logic a_we;
      logic irq;
      logic tb_irq;
      logic wk_irq;
      logic wd_rst;
      logic fetch_go;
      logic [11:0] pc;
      logic [31:0] hrdata;
      logic hready;
   } tiw_regs_t;

endpackage

/* sim/timebase_idle_watchdog_tb.sv */
`timescale 1ns/10ps
module timebase_idle_watchdog_tb
   import tiw_pkg::*;
;
   logic mclk_i = 0, srst_i = 1, hsel_i = 0, hwrite_i = 0, idle_req_i = 0, wake_pend_i = 0;
   logic prog_mode_i = 0, write_protect_i = 0;
   logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd;
   logic [1:0] htrans_i = 0;
   logic hreadyout_o, idle_o, tbi, wki, irq_o, wdt_o, fetch_o, fuse_o;
   logic [11:0] pc;
   int failures = 0, compares = 0, n;
   tiw_top DUT (.mclk_i(mclk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
      .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(), .idle_req_i(idle_req_i), .wake_pend_i(wake_pend_i),
      .prog_mode_i(prog_mode_i), .write_protect_i(write_protect_i), .fuse_init_i(1'b1), .idle_o(idle_o),
      .timebase_interrupt_o(tbi), .wake_irq_o(wki), .irq_o(irq_o), .wdt_reset_o(wdt_o),
      .watchdog_enable_fuse_o(fuse_o), .fetch_start_o(fetch_o), .fetch_pc_o(pc));
   initial begin
      forever #12.5 mclk_i = ~mclk_i;
   end
   // Each phase holds until hready is seen high at a rising edge; one idle cycle follows.
   task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
      hsel_i <= 1'b1;
      haddr_i <= {20'h0, idx, 2'b00};
      htrans_i <= 2'h2;
      hwrite_i <= w;
      do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
      @(posedge mclk_i);
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic rdc(input string s, input logic [9:0] idx, input logic [31:0] e);
      bus(1'b0, idx, 32'h0);
      chk(s, e, rd);
   endtask
   // Waits for an output to reach a level; n returns the cycles taken.
   task automatic wt(input int k, input logic v, input int lim);
      logic [3:0] o;
      for (n = 1; n <= lim; n++) begin
         @(negedge mclk_i);
         o = {fetch_o, wdt_o, idle_o, tbi};
         if (o[k] === v) break;
      end
      @(posedge mclk_i);
      chk("wait", 32'h1, 32'(n <= lim));
   endtask
   task automatic end_sim();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #2500000;
      failures++;
      end_sim();
   end
   initial begin
      repeat (6) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(posedge mclk_i);
      rdc("ctl_rst", IDX_CONTROL, 32'h0);
      bus(1'b1, IDX_CONTROL, 32'hFF);
      rdc("ctl_rw", IDX_CONTROL, 32'h81);
      rdc("unmapped", 10'h3FF, 32'h0);
      bus(1'b1, IDX_FUSE, 32'h0);
      rdc("fuse_lock", IDX_FUSE, 32'h1);
      prog_mode_i <= 1'b1;
      write_protect_i <= 1'b1;
      bus(1'b1, IDX_FUSE, 32'h0);
      rdc("fuse_prot", IDX_FUSE, 32'h7);
      chk("fuse_pin", 32'h1, 32'(fuse_o));
      wt(0, 1'b1, 4200);
      chk("wrap_time", 32'h1, 32'(n > 4000));
      bus(1'b1, IDX_CONTROL, 32'h03);
      rdc("flag_keep", IDX_CONTROL, 32'h03);
      rdc("sts_ovf", IDX_STATUS, 32'h1);
      bus(1'b1, IDX_MASK, 32'h1);
      chk("irq_on", 32'h1, 32'(irq_o));
      bus(1'b1, IDX_STATUS, 32'h1);
      bus(1'b1, IDX_CONTROL, 32'h01);
      chk("tb_irq_off", 32'h0, 32'(tbi));
      chk("irq_off", 32'h0, 32'(irq_o));
      idle_req_i <= 1'b1;
      @(posedge mclk_i);
      idle_req_i <= 1'b0;
      wt(1, 1'b0, 8300);
      chk("idle_time", 32'h1, 32'(n > 4000));
      rdc("sts_wake", IDX_STATUS, 32'h3);
      bus(1'b1, IDX_CONTROL, 32'h80);
      idle_req_i <= 1'b1;
      @(posedge mclk_i);
      idle_req_i <= 1'b0;
      wake_pend_i <= 1'b1;
      wt(1, 1'b0, 4);
      chk("wake_irq", 32'h1, 32'(wki));
      wake_pend_i <= 1'b0;
      bus(1'b1, IDX_SERVICE, {24'h0, SERVICE_KEY});
      bus(1'b1, IDX_SERVICE, {24'h0, SERVICE_KEY});
      wt(2, 1'b1, 4);
      wt(3, 1'b1, 40);
      chk("pc", 32'hC00, 32'(pc));
      rdc("ctl_clr", IDX_CONTROL, 32'h0);
      repeat (4100) @(posedge mclk_i);
      bus(1'b1, IDX_SERVICE, {24'h0, SERVICE_KEY});
      bus(1'b1, IDX_SERVICE, 32'h55);
      wt(2, 1'b1, 66000);
      chk("expiry", 32'h1, 32'(n > 57344 && n <= 61440));
      end_sim();
   end
endmodule // timebase_idle_watchdog_tb

/* sim/tiw_asserts.sv */
`timescale 1ns/10ps
module tiw_asserts
   import tiw_pkg::*;
(
   // Watched ports
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic hsel_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic idle_req_i,
   input wire logic wake_pend_i,
   input wire logic idle_o,
   input wire logic wake_irq_o,
   input wire logic wdt_reset_o,
   input wire logic watchdog_enable_fuse_o,
   input wire logic fetch_start_o,
   input wire logic [11:0] fetch_pc_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   bus_okay_a: assert property (hreadyout_o && !hresp_o) else $error("bus not ready or error");
   read_only_a: assert property (hrdata_o != 32'h0 |-> $past(hsel_i && htrans_i[1] && !hwrite_i && hready_i))
      else $error("read data without a read");
   wake_irq_a: assert property (wake_irq_o |-> $past(wake_pend_i)) else $error("wake irq without pending");
   fuse_gate_a: assert property ($rose(wdt_reset_o) |-> $past(watchdog_enable_fuse_o))
      else $error("watchdog reset with fuse clear");
   reset_hold_a: assert property ($rose(wdt_reset_o) |-> wdt_reset_o [*8]) else $error("reset hold short");
   fetch_go_a: assert property ($fell(wdt_reset_o) |-> ##[0:2] fetch_start_o) else $error("no fetch");
   fetch_pc_a: assert property (fetch_start_o |-> fetch_pc_o == RESTART_PC) else $error("bad pc");
   fetch_one_a: assert property (fetch_start_o |=> !fetch_start_o) else $error("fetch pulse long");
   idle_entry_a: assert property ($rose(idle_o) |-> $past(idle_req_i)) else $error("idle without request");
endmodule // tiw_asserts
bind tiw_top tiw_asserts u_chk (.mclk_i(mclk_i), .srst_i(srst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
   .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .idle_req_i(idle_req_i), .wake_pend_i(wake_pend_i), .idle_o(idle_o), .wake_irq_o(wake_irq_o),
   .wdt_reset_o(wdt_reset_o), .watchdog_enable_fuse_o(watchdog_enable_fuse_o), .fetch_start_o(fetch_start_o),
   .fetch_pc_o(fetch_pc_o));
